// ---- design/rwb_regs.svh ----
// register offsets, field positions and reset values of the window bounds
`ifndef RWB_REGS_SVH
`define RWB_REGS_SVH

`define RWB_OFS_ROW_START 8'h19
`define RWB_OFS_ROW_END 8'h1A
`define RWB_OFS_ROW_LOW 8'h1B
`define RWB_OFS_COL_START 8'h1C
`define RWB_OFS_COL_END 8'h1D

`define RWB_RST_ROW_START 8'h00
`define RWB_RST_ROW_END 8'h1B
`define RWB_RST_ROW_LOW 6'h23
`define RWB_RST_COL_START 8'h00
`define RWB_RST_COL_END 8'h28

`define RWB_POS_START_ROW_B2 5
`define RWB_POS_END_ROW_B2 2
`define RWB_LOW_WIDTH 6

`define RWB_FIX_START_LOW 2'h0
`define RWB_FIX_END_LOW 2'h3

`endif

// ---- design/rwb_pkg.sv ----
// types shared by the window bounds register group
`default_nettype none
package rwb_pkg;
	typedef logic [10:0] rwb_addr_t;
	typedef logic [7:0] rwb_byte_t;
	typedef enum logic [1:0] {
		RWB_IN_SYNC = 2'b00,
		RWB_PENDING = 2'b01
	} rwb_state_t;
endpackage : rwb_pkg
`default_nettype wire

// ---- design/rwb_bounds_if.sv ----
// staged window bounds passed from the register file to the shadow copy
`default_nettype none
interface rwb_bounds_if;
	rwb_pkg::rwb_addr_t first_row;
	rwb_pkg::rwb_addr_t last_row;
	rwb_pkg::rwb_addr_t first_col;
	rwb_pkg::rwb_addr_t last_col;
	logic load;
	modport src (output first_row, last_row, first_col, last_col, load);
	modport dst (input first_row, last_row, first_col, last_col, load);
endinterface : rwb_bounds_if
`default_nettype wire

// ---- design/rwb_shadow.sv ----
// shadow copy of the window bounds, taken over at a frame boundary
`include "rwb_regs.svh"
`default_nettype none
module rwb_shadow (
	input wire logic clk,                              // system clock
	input wire logic sys_rst,                          // async reset, high
	rwb_bounds_if.dst stg,                             // staged bounds
	output rwb_pkg::rwb_addr_t first_row_address,      // live first row
	output rwb_pkg::rwb_addr_t last_row_address,       // live last row
	output rwb_pkg::rwb_addr_t first_column_address,   // live first column
	output rwb_pkg::rwb_addr_t last_column_address     // live last column
);
	rwb_pkg::rwb_addr_t frow_ff, lrow_ff, fcol_ff, lcol_ff;
	rwb_pkg::rwb_addr_t nxt_frow, nxt_lrow, nxt_fcol, nxt_lcol;

	always_comb begin
		nxt_frow = frow_ff;
		nxt_lrow = lrow_ff;
		nxt_fcol = fcol_ff;
		nxt_lcol = lcol_ff;
		if (stg.load) begin
			nxt_frow = stg.first_row;
			nxt_lrow = stg.last_row;
			nxt_fcol = stg.first_col;
			nxt_lcol = stg.last_col;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			frow_ff <= {`RWB_RST_ROW_START, 1'b1, `RWB_FIX_START_LOW};
			lrow_ff <= {`RWB_RST_ROW_END, 1'b0, `RWB_FIX_END_LOW};
			fcol_ff <= {`RWB_RST_COL_START, 1'b0, `RWB_FIX_START_LOW};
			lcol_ff <= {`RWB_RST_COL_END, 1'b1, `RWB_FIX_END_LOW};
		end else begin
			frow_ff <= nxt_frow;
			lrow_ff <= nxt_lrow;
			fcol_ff <= nxt_fcol;
			lcol_ff <= nxt_lcol;
		end
	end

	assign first_row_address = frow_ff;
	assign last_row_address = lrow_ff;
	assign first_column_address = fcol_ff;
	assign last_column_address = lcol_ff;
endmodule : rwb_shadow
`default_nettype wire

// ---- design/rwb_window_regs.sv ----
// active readout window bounds register group with frame-aligned shadow
//
// Contract
// - first row bits 10:3 come from the whole row start register.
// - last row bits 10:3 come from the whole row end register.
// - row low bits register bit 5 is first row bit 2.
// - first row bits 1:0 are zero; low register bits 4:3 ignored.
// - row low bits register bit 2 is last row bit 2.
// - last row bits 1:0 are 11; low register bits 1:0 ignored.
// - first column bits 10:3 come from the column start register.
// - last column bits 10:3 come from column end register at 1D.
// - first column bits 1:0 are zero whatever is written.
`include "rwb_regs.svh"
`default_nettype none
module rwb_window_regs (
	input wire logic clk,                              // system clock
	input wire logic sys_rst,                          // async reset, high
	input wire logic [7:0] reg_addr,                   // register address
	input wire logic [7:0] reg_wdata,                  // write data
	input wire logic reg_wr,                           // write strobe
	input wire logic reg_rd,                           // read strobe
	output logic [7:0] reg_rdata,                      // read data
	input wire logic frame_start,                      // frame boundary
	input wire logic col_start_bit2,                   // first column bit 2
	input wire logic col_end_bit2,                     // last column bit 2
	output rwb_pkg::rwb_addr_t first_row_address,      // live first row
	output rwb_pkg::rwb_addr_t last_row_address,       // live last row
	output rwb_pkg::rwb_addr_t first_column_address,   // live first column
	output rwb_pkg::rwb_addr_t last_column_address,    // live last column
	output logic update_pending                        // staged not yet live
);
	rwb_pkg::rwb_byte_t row_start_ff, row_end_ff, col_start_ff, col_end_ff;
	rwb_pkg::rwb_byte_t nxt_row_start, nxt_row_end;
	rwb_pkg::rwb_byte_t nxt_col_start, nxt_col_end;
	logic [`RWB_LOW_WIDTH-1:0] row_low_ff, nxt_row_low;
	rwb_pkg::rwb_byte_t rdata_ff, nxt_rdata;
	rwb_pkg::rwb_state_t state_ff, nxt_state;
	logic wr_hit;

	rwb_bounds_if stg ();

	function automatic rwb_pkg::rwb_byte_t read_mux(
		input logic [7:0] a,
		input rwb_pkg::rwb_byte_t rs,
		input rwb_pkg::rwb_byte_t re,
		input logic [`RWB_LOW_WIDTH-1:0] lo,
		input rwb_pkg::rwb_byte_t cs,
		input rwb_pkg::rwb_byte_t ce
	);
		rwb_pkg::rwb_byte_t d;
		case (a)
			`RWB_OFS_ROW_START: d = rs;
			`RWB_OFS_ROW_END: d = re;
			`RWB_OFS_ROW_LOW: d = {2'h0, lo};
			`RWB_OFS_COL_START: d = cs;
			`RWB_OFS_COL_END: d = ce;
			default: d = 8'h00;
		endcase
		return d;
	endfunction : read_mux

	// register writes; low bits 4:3 and 1:0 are stored for readback only
	always_comb begin
		nxt_row_start = row_start_ff;
		nxt_row_end = row_end_ff;
		nxt_row_low = row_low_ff;
		nxt_col_start = col_start_ff;
		nxt_col_end = col_end_ff;
		wr_hit = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				`RWB_OFS_ROW_START: begin
					nxt_row_start = reg_wdata;
					wr_hit = 1'b1;
				end
				`RWB_OFS_ROW_END: begin
					nxt_row_end = reg_wdata;
					wr_hit = 1'b1;
				end
				`RWB_OFS_ROW_LOW: begin
					nxt_row_low = reg_wdata[`RWB_LOW_WIDTH-1:0];
					wr_hit = 1'b1;
				end
				`RWB_OFS_COL_START: begin
					nxt_col_start = reg_wdata;
					wr_hit = 1'b1;
				end
				`RWB_OFS_COL_END: begin
					nxt_col_end = reg_wdata;
					wr_hit = 1'b1;
				end
				default: wr_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			row_start_ff <= `RWB_RST_ROW_START;
			row_end_ff <= `RWB_RST_ROW_END;
			row_low_ff <= `RWB_RST_ROW_LOW;
			col_start_ff <= `RWB_RST_COL_START;
			col_end_ff <= `RWB_RST_COL_END;
		end else begin
			row_start_ff <= nxt_row_start;
			row_end_ff <= nxt_row_end;
			row_low_ff <= nxt_row_low;
			col_start_ff <= nxt_col_start;
			col_end_ff <= nxt_col_end;
		end
	end

	// read data is registered; unmapped addresses read zero
	always_comb begin
		nxt_rdata = rdata_ff;
		if (reg_rd) begin
			nxt_rdata = read_mux(reg_addr, row_start_ff, row_end_ff,
				row_low_ff, col_start_ff, col_end_ff);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	// pending tracks staged changes; a write in the frame cycle stays pending
	always_comb begin
		case (state_ff)
			rwb_pkg::RWB_IN_SYNC: begin
				nxt_state = wr_hit ? rwb_pkg::RWB_PENDING
					: rwb_pkg::RWB_IN_SYNC;
			end
			rwb_pkg::RWB_PENDING: begin
				nxt_state = (frame_start && !wr_hit) ? rwb_pkg::RWB_IN_SYNC
					: rwb_pkg::RWB_PENDING;
			end
			default: nxt_state = rwb_pkg::RWB_IN_SYNC;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= rwb_pkg::RWB_IN_SYNC;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign update_pending = (state_ff == rwb_pkg::RWB_PENDING);

	// staged bounds assembled from the byte registers and the column bit 2 pins
	assign stg.first_row = {row_start_ff,
		row_low_ff[`RWB_POS_START_ROW_B2],
		`RWB_FIX_START_LOW};
	assign stg.last_row = {row_end_ff,
		row_low_ff[`RWB_POS_END_ROW_B2],
		`RWB_FIX_END_LOW};
	assign stg.first_col = {col_start_ff, col_start_bit2,
		`RWB_FIX_START_LOW};
	assign stg.last_col = {col_end_ff, col_end_bit2, `RWB_FIX_END_LOW};
	assign stg.load = frame_start;

	rwb_shadow u_shadow (
		.clk(clk),
		.sys_rst(sys_rst),
		.stg(stg),
		.first_row_address(first_row_address),
		.last_row_address(last_row_address),
		.first_column_address(first_column_address),
		.last_column_address(last_column_address)
	);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_row_start_high: assert property (
		frame_start |=> first_row_address[10:3] == $past(row_start_ff))
		else $error("first row high bits not from row start register");
	a_row_end_high: assert property (
		frame_start |=> last_row_address[10:3] == $past(row_end_ff))
		else $error("last row high bits not from row end register");
	a_start_row_b2: assert property (
		frame_start |=> first_row_address[2] == $past(row_low_ff[5]))
		else $error("first row bit 2 not from low register bit 5");
	a_start_row_low: assert property (
		first_row_address[1:0] == 2'h0)
		else $error("first row low bits not zero");
	a_end_row_b2: assert property (
		frame_start |=> last_row_address[2] == $past(row_low_ff[2]))
		else $error("last row bit 2 not from low register bit 2");
	a_end_row_low: assert property (
		last_row_address[1:0] == 2'h3)
		else $error("last row low bits not 11");
	a_col_start_high: assert property (
		frame_start |=> first_column_address[10:3] == $past(col_start_ff))
		else $error("first column high bits not from start register");
	a_col_end_write: assert property (
		reg_wr && reg_addr == `RWB_OFS_COL_END
		|=> col_end_ff == $past(reg_wdata))
		else $error("column end register at 1D not written");
	a_col_start_low: assert property (
		first_column_address[1:0] == 2'h0)
		else $error("first column low bits not zero");
	a_frame_hold: assert property (
		!frame_start |=> $stable(first_row_address)
		&& $stable(last_row_address) && $stable(first_column_address)
		&& $stable(last_column_address))
		else $error("live bounds changed outside a frame boundary");
	a_pending_clear: assert property (
		update_pending && frame_start && !wr_hit |=> !update_pending)
		else $error("pending not cleared at frame boundary");

	c_row_write_apply: cover property (
		reg_wr && reg_addr == `RWB_OFS_ROW_LOW ##[1:20] frame_start);
	c_write_at_frame: cover property (wr_hit && frame_start);
	c_unmapped_read: cover property (reg_rd && reg_addr == 8'h1E);
	c_pending_held: cover property (update_pending [*4] ##1 frame_start);
endmodule : rwb_window_regs
`default_nettype wire

// ---- tb/tb_readout_window_bounds_regs.sv ----
// self-checking bench for the readout window bounds register group
`default_nettype none
module tb_readout_window_bounds_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, sys_rst, reg_wr, reg_rd, frame_start;
	logic col_start_bit2, col_end_bit2, update_pending;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	rwb_pkg::rwb_addr_t first_row_address, last_row_address;
	rwb_pkg::rwb_addr_t first_column_address, last_column_address;
	logic [7:0] st [5];
	logic [10:0] lv [4];
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;

	rwb_window_regs u_rwb_window_regs (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .frame_start(frame_start),
		.col_start_bit2(col_start_bit2), .col_end_bit2(col_end_bit2),
		.first_row_address(first_row_address),
		.last_row_address(last_row_address),
		.first_column_address(first_column_address),
		.last_column_address(last_column_address),
		.update_pending(update_pending)
	);

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [10:0] e,
		input logic [10:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	// expected bound k from the staged model and the column pins
	function automatic logic [10:0] bnd(input int k);
		case (k)
			0: return {st[0], st[2][5], 2'h0};
			1: return {st[1], st[2][2], 2'h3};
			2: return {st[3], col_start_bit2, 2'h0};
			default: return {st[4], col_end_bit2, 2'h3};
		endcase
	endfunction : bnd

	function automatic bit mapped(input logic [7:0] a);
		return a >= 8'h19 && a <= 8'h1D;
	endfunction : mapped

	task automatic stage(input logic [7:0] a, input logic [7:0] d);
		if (mapped(a))
			st[a - 8'h19] = (a == 8'h1B) ? (d & 8'h3F) : d;
	endtask : stage

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		stage(a, d);
		// one idle edge so a following request never re-drives the strobe
		@(posedge clk);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", {3'h0, mapped(a) ? st[a - 8'h19] : 8'h00},
			{3'h0, reg_rdata});
		@(posedge clk);
	endtask : rd_chk

	// checks live bounds and the pending flag, then realigns to the clock
	task automatic settle(input logic pend);
		#1;
		chk("first_row_address", lv[0], first_row_address);
		chk("last_row_address", lv[1], last_row_address);
		chk("first_column_address", lv[2], first_column_address);
		chk("last_column_address", lv[3], last_column_address);
		chk("update_pending", {10'h000, pend}, {10'h000, update_pending});
		@(posedge clk);
	endtask : settle

	// frame boundary, optionally with a write landing in the same cycle
	task automatic frame(input logic [7:0] a, input logic [7:0] d,
		input logic w);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		frame_start <= 1'b1;
		@(posedge clk);
		frame_start <= 1'b0;
		reg_wr <= 1'b0;
		for (int k = 0; k < 4; k++)
			lv[k] = bnd(k);
		if (w)
			stage(a, d);
		settle(w);
	endtask : frame

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			end_sim;
		end
	end

	initial begin
		logic [7:0] d;
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		frame_start = 1'b0;
		col_start_bit2 = 1'b0;
		col_end_bit2 = 1'b1;
		st = '{8'h00, 8'h1B, 8'h23, 8'h00, 8'h28};
		lv = '{11'h004, 11'h0DB, 11'h000, 11'h147};
		void'($urandom(2688));
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		settle(1'b0);
		for (int a = 8'h18; a <= 8'h1E; a++)
			rd_chk(8'(a));
		// host programs every bound after power-up
		for (int a = 8'h19; a <= 8'h1D; a++)
			wr(8'(a), 8'($urandom));
		wr(8'h1E, 8'($urandom));
		settle(1'b1);
		for (int a = 8'h18; a <= 8'h1E; a++)
			rd_chk(8'(a));
		frame(8'h00, 8'h00, 1'b0);
		for (int i = 0; i < 40; i++) begin
			col_start_bit2 <= 1'($urandom);
			col_end_bit2 <= 1'($urandom);
			d = (i < 4) ? {8{i[0]}} : 8'($urandom);
			wr(8'h19 + 8'($urandom % 5), d);
			wr(8'h1B, ~d);
			if (i % 3 == 0) begin
				frame(8'h19 + 8'($urandom % 5), 8'($urandom), 1'b1);
				rd_chk(8'h1B);
			end else begin
				settle(1'b1);
				frame(8'h00, 8'h00, 1'b0);
			end
		end
		end_sim;
	end
endmodule : tb_readout_window_bounds_regs
`default_nettype wire
